// ==== logic/upl_cfg.svh ====
// constants for the port line control block
`ifndef UPL_CFG_SVH
`define UPL_CFG_SVH
`define UPL_PORT_CTRL_ADDR 8'h05
`define UPL_PORT_CTRL_RESET 8'h00
`define UPL_BIT_SUSPEND 6
`define UPL_BIT_SPEED 5
`define UPL_BIT_FORCE 4
`define UPL_BIT_ENG_RST 3
`define UPL_BIT_RSVD2 2
`define UPL_BIT_SOF_EN 0
`define UPL_RD_MASK 8'h7D
`endif

// ==== logic/upl_pkg.sv ====
// types for the port line control block
`default_nettype none
package upl_pkg;
  typedef enum logic [1:0] {
    UPL_LINE_IDLE = 2'b00,
    UPL_LINE_SE0 = 2'b01,
    UPL_LINE_J = 2'b10,
    UPL_LINE_K = 2'b11
  } upl_line_t;
  typedef enum logic [0:0] {
    UPL_RUN = 1'b0,
    UPL_SUSP = 1'b1
  } upl_pwr_t;
endpackage
`default_nettype wire

// ==== logic/upl_port_line_control.sv ====
// port control register with suspend, speed, forced line states and frame gating
// Functional notes
// - suspend powers transceiver, ram, clocks down
// - bus activity while suspended resumes operation
// - speed bit: 0 full, 1 low; resets 0
// - force 0: engine reset drives se0
// - force 1: J or K by reset bit
// - forced J and K levels do not depend on speed
// - register cleared to zero at power-up
// - suspend retargets detect enable to resume
`timescale 1ns/1ps
`default_nettype none
`include "upl_cfg.svh"
module upl_port_line_control (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic cpu_cs_n,
  input wire logic cpu_wr_n,
  input wire logic cpu_rd_n,
  input wire logic address_select_line,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic [7:0] reg_addr,
  input wire logic line_dp_in,
  input wire logic line_dm_in,
  input wire logic detect_int_en,
  input wire logic sof_token_req,
  output logic sof_token_out,
  output logic line_dp_out,
  output logic line_dm_out,
  output logic line_oe,
  output logic tx_power_down,
  output logic ram_suspend,
  output logic clk_gate_off,
  output logic low_speed,
  output logic resume_int_en,
  output logic detect_en
);
  logic [7:0] ctrl;
  upl_pkg::upl_pwr_t pwr;
  upl_pkg::upl_line_t line_mode;
  logic wr_strobe;
  logic wr_hit;
  logic bus_activity;
  logic cpu_wake;

  // one data-phase write; the address register is kept outside this block
  assign wr_strobe = !cpu_cs_n && !cpu_wr_n && address_select_line;
  assign wr_hit = wr_strobe && (reg_addr == `UPL_PORT_CTRL_ADDR);
  // only a K level for the current speed counts as activity; J and se0 do not
  assign bus_activity = line_dp_in != line_dm_in ? (line_dm_in != ctrl[`UPL_BIT_SPEED]) : 1'b0;
  assign cpu_wake = wr_strobe;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      ctrl <= `UPL_PORT_CTRL_RESET;
    else if (wr_hit)
      ctrl <= cpu_wdata;
    else if (pwr == upl_pkg::UPL_SUSP && (bus_activity || cpu_wake))
      ctrl[`UPL_BIT_SUSPEND] <= 1'b0;
  end

  // suspend state follows the bit; a write while suspended exits first
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      pwr <= upl_pkg::UPL_RUN;
    else
      case (pwr)
        upl_pkg::UPL_RUN:
          if (ctrl[`UPL_BIT_SUSPEND] && !wr_strobe)
            pwr <= upl_pkg::UPL_SUSP;
        upl_pkg::UPL_SUSP:
          if (bus_activity || cpu_wake)
            pwr <= upl_pkg::UPL_RUN;
        default:
          pwr <= upl_pkg::UPL_RUN;
      endcase
  end

  assign tx_power_down = (pwr == upl_pkg::UPL_SUSP);
  assign ram_suspend = (pwr == upl_pkg::UPL_SUSP);
  assign clk_gate_off = (pwr == upl_pkg::UPL_SUSP);
  assign low_speed = ctrl[`UPL_BIT_SPEED];

  always_comb
  begin
    case ({ctrl[`UPL_BIT_FORCE], ctrl[`UPL_BIT_ENG_RST]})
      2'b00: line_mode = upl_pkg::UPL_LINE_IDLE;
      2'b01: line_mode = upl_pkg::UPL_LINE_SE0;
      2'b10: line_mode = upl_pkg::UPL_LINE_J;
      2'b11: line_mode = upl_pkg::UPL_LINE_K;
      default: line_mode = upl_pkg::UPL_LINE_IDLE;
    endcase
  end

  // levels fixed by code; at low speed code J shows as a low speed K and K as J
  // the polarity swap that low speed devices need sits outside this block
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      line_dp_out <= 1'b0;
      line_dm_out <= 1'b0;
      line_oe <= 1'b0;
    end
    else
    begin
      line_oe <= (line_mode != upl_pkg::UPL_LINE_IDLE) && (pwr == upl_pkg::UPL_RUN);
      case (line_mode)
        upl_pkg::UPL_LINE_SE0:
        begin
          line_dp_out <= 1'b0;
          line_dm_out <= 1'b0;
        end
        upl_pkg::UPL_LINE_J:
        begin
          line_dp_out <= 1'b1;
          line_dm_out <= 1'b0;
        end
        upl_pkg::UPL_LINE_K:
        begin
          line_dp_out <= 1'b0;
          line_dm_out <= 1'b1;
        end
        default:
        begin
          line_dp_out <= 1'b0;
          line_dm_out <= 1'b0;
        end
      endcase
    end
  end

  // frame generation keeps running upstream; only the token is gated
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      sof_token_out <= 1'b0;
    else
      sof_token_out <= sof_token_req && ctrl[`UPL_BIT_SOF_EN] && (pwr == upl_pkg::UPL_RUN);
  end

  assign resume_int_en = detect_int_en && ctrl[`UPL_BIT_SUSPEND];
  assign detect_en = detect_int_en && !ctrl[`UPL_BIT_SUSPEND];

  // bit 2 reads back but steers nothing
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      cpu_rdata <= 8'h00;
    else if (!cpu_cs_n && !cpu_rd_n && reg_addr == `UPL_PORT_CTRL_ADDR)
      cpu_rdata <= ctrl & `UPL_RD_MASK;
    else
      cpu_rdata <= 8'h00;
  end

  a_reset_clear: assert property (@(posedge core_clk) $rose(rstn) |-> ctrl == 8'h00)
    else $error("control not cleared at reset");
  a_se0_drive: assert property (@(posedge core_clk) disable iff (!rstn)
    (line_mode == upl_pkg::UPL_LINE_SE0 && pwr == upl_pkg::UPL_RUN) ##1
    $stable(ctrl) |-> line_oe && !line_dp_out && !line_dm_out)
    else $error("se0 not driven");
  a_force_j: assert property (@(posedge core_clk) disable iff (!rstn)
    (line_mode == upl_pkg::UPL_LINE_J) |=> line_dp_out && !line_dm_out)
    else $error("forced j level wrong");
  a_force_k: assert property (@(posedge core_clk) disable iff (!rstn)
    (line_mode == upl_pkg::UPL_LINE_K) |=> !line_dp_out && line_dm_out)
    else $error("forced k level wrong");
  a_wake_bus: assert property (@(posedge core_clk) disable iff (!rstn)
    (pwr == upl_pkg::UPL_SUSP && bus_activity && !wr_hit) |=> pwr == upl_pkg::UPL_RUN)
    else $error("no resume on bus activity");
  a_wake_cpu: assert property (@(posedge core_clk) disable iff (!rstn)
    (pwr == upl_pkg::UPL_SUSP && cpu_wake) |=> !tx_power_down)
    else $error("no resume on data write");
  a_sof_gate: assert property (@(posedge core_clk) disable iff (!rstn)
    sof_token_out |-> $past(ctrl[0]) && $past(sof_token_req))
    else $error("frame token leaked");
  a_rsvd_read: assert property (@(posedge core_clk) disable iff (!rstn)
    cpu_rdata[7] == 1'b0 && cpu_rdata[1] == 1'b0)
    else $error("reserved bits read nonzero");
  a_suspend_down: assert property (@(posedge core_clk) disable iff (!rstn)
    (ctrl[6] && pwr == upl_pkg::UPL_RUN && !wr_strobe) |=> tx_power_down && clk_gate_off)
    else $error("suspend did not power down");
  a_detect_sel: assert property (@(posedge core_clk) disable iff (!rstn)
    !(resume_int_en && detect_en) && (detect_int_en == (resume_int_en || detect_en)))
    else $error("detect enable routing wrong");
  a_reset_outputs: assert property (@(posedge core_clk) $rose(rstn) |->
    !line_oe && !sof_token_out && cpu_rdata == 8'h00)
    else $error("outputs not cleared at reset");
  a_speed_write: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_hit |=> low_speed == $past(cpu_wdata[`UPL_BIT_SPEED]))
    else $error("speed bit not written");
  a_idle_release: assert property (@(posedge core_clk) disable iff (!rstn)
    (line_mode == upl_pkg::UPL_LINE_IDLE) |=> !line_oe)
    else $error("line driven in normal mode");
  a_tx_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
    (pwr == upl_pkg::UPL_SUSP) |=> !line_oe)
    else $error("line driven while suspended");
  a_sof_pass: assert property (@(posedge core_clk) disable iff (!rstn)
    (ctrl[`UPL_BIT_SOF_EN] && sof_token_req && pwr == upl_pkg::UPL_RUN) |=> sof_token_out)
    else $error("frame token dropped");
  a_sof_suspend: assert property (@(posedge core_clk) disable iff (!rstn)
    (pwr == upl_pkg::UPL_SUSP) |=> !sof_token_out)
    else $error("frame token sent while suspended");
  a_wake_clear: assert property (@(posedge core_clk) disable iff (!rstn)
    (pwr == upl_pkg::UPL_SUSP && (bus_activity || cpu_wake) && !wr_hit) |=>
    !ctrl[`UPL_BIT_SUSPEND])
    else $error("suspend bit not cleared on wake");
endmodule
`default_nettype wire

// ==== tb/upl_usb_dev.sv ====
// attached usb device model
`timescale 1ns/1ps
`default_nettype none
module upl_usb_dev (
  input wire logic ls,
  input wire logic wake,
  output logic dp,
  output logic dm
);
  // idle shows j for the speed, wake shows k
  assign dp = ls ^ ~wake;
  assign dm = ls ^ wake;
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the port line control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 0, rstn = 0, cs_n = 1, wr_n = 1, rd_n = 1, wake = 0, smp = 0;
  logic a0 = 1, sreq = 1, die = 1;
  logic [7:0] wd = 8'h00, ad = 8'h05, v, rdata;
  logic dpo, dmo, oe, sof, pd, rs, ck, ls, rie, de, dpd, dmd;
  logic [17:0] q[$];
  int failures = 0, n_tests = 0, seed = 32'h21CD, i;
  // cable level: dut drive wins over the device while enabled
  wire logic dpi = oe ? dpo : dpd;
  wire logic dmi = oe ? dmo : dmd;
  wire logic [17:0] obs = {rdata, oe, oe & dpo, oe & dmo, ls, sof, pd, rs, ck, rie, de};
  initial forever #5 core_clk = ~core_clk;
  upl_port_line_control dut (.core_clk(core_clk), .rstn(rstn), .cpu_cs_n(cs_n),
    .cpu_wr_n(wr_n), .cpu_rd_n(rd_n), .address_select_line(a0), .cpu_wdata(wd),
    .cpu_rdata(rdata), .reg_addr(ad), .line_dp_in(dpi), .line_dm_in(dmi),
    .detect_int_en(die), .sof_token_req(sreq), .sof_token_out(sof), .line_dp_out(dpo),
    .line_dm_out(dmo), .line_oe(oe), .tx_power_down(pd), .ram_suspend(rs),
    .clk_gate_off(ck), .low_speed(ls), .resume_int_en(rie), .detect_en(de));
  upl_usb_dev dev (.ls(ls), .wake(wake), .dp(dpd), .dm(dmd));
  function automatic logic [17:0] ex(input logic [7:0] c);
    // forced levels do not depend on speed; suspend drops the drive
    return {c & 8'h7D, (c[4] | c[3]) & ~c[6], c[4] & ~c[3] & ~c[6], c[4] & c[3] & ~c[6],
      c[5], c[0] & ~c[6] & sreq, {3{c[6]}}, c[6] & die, ~c[6] & die};
  endfunction
  task automatic check(input logic [17:0] s, input logic [17:0] e);
    n_tests++;
    if (s !== e)
    begin
      failures++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    ad = a;
    wd = d;
    cs_n = 0;
    wr_n = 0;
    @(posedge core_clk) #1;
    cs_n = 1;
    wr_n = 1;
    ad = 8'h05;
  endtask
  // settle margin so line and power outputs have landed before the read
  task automatic rd(input logic [17:0] e);
    repeat (3) @(posedge core_clk);
    #1;
    cs_n = 0;
    rd_n = 0;
    @(posedge core_clk) #1;
    cs_n = 1;
    rd_n = 1;
    q.push_back(e);
    smp = 1;
    @(posedge core_clk) #1;
    smp = 0;
  endtask
  // read data stands for one cycle only; look at it mid-cycle
  always @(negedge core_clk)
    if (smp)
      check(obs, q.pop_front());
  task automatic stop_test;
    $display("counts: %0d compares, %0d mismatches", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk);
    #1;
    rstn = 1;
    rd(ex(8'h00));
    // bus reset held only a few cycles here; the long hold is up to software
    wr(8'h05, 8'h08);
    rd(ex(8'h08));
    wr(8'h05, 8'h00);
    wr(8'h05, 8'h01);
    rd(ex(8'h01));
    $display("test reset done");
    for (i = 0; i < 16; i++)
    begin
      v = 8'($random(seed)) & 8'h87 | {2'b00, i[2:0], 3'b000};
      sreq = 1'($random(seed));
      die = 1'($random(seed));
      wr(8'h05, v);
      rd(ex(v));
    end
    $display("test line codes done");
    wr(8'h05, 8'h41);
    rd(ex(8'h41));
    wake = 1;
    repeat (4) @(posedge core_clk);
    #1;
    wake = 0;
    rd(ex(8'h01));
    wr(8'h05, 8'h40);
    // an address-phase write alone must not wake the block
    a0 = 0;
    wr(8'h05, 8'h00);
    a0 = 1;
    rd(ex(8'h40));
    wr(8'h06, 8'h5A);
    rd(ex(8'h00));
    $display("test suspend done");
    wr(8'h05, 8'h3D);
    rstn = 0;
    repeat (2) @(posedge core_clk);
    #1;
    rstn = 1;
    rd(ex(8'h00));
    $display("test mid reset done");
    stop_test;
  end
  initial
  begin
    #20000;
    failures++;
    stop_test;
  end
endmodule
`default_nettype wire
